// ---- common/rff_pkg.sv ----
// Constants, register map and entry type of the receive frame FIFO.
// Assumes a 32-bit APB register bus with byte addresses.
`default_nettype none
package rff_pkg;
    // Message buffer storage
    localparam int NUM_BUF = 16;
    localparam int IDX_W = 4;
    localparam int NUM_DED = 4;
    localparam logic [7:0] LAST_BUF = 8'h0f;

    // Register byte offsets
    localparam logic [11:0] OFS_FILTER = 12'h000;
    localparam logic [11:0] OFS_MASK = 12'h004;
    localparam logic [11:0] OFS_CRIT = 12'h008;
    localparam logic [11:0] OFS_RAMCFG = 12'h00c;
    localparam logic [11:0] OFS_ERRFLG = 12'h010;
    localparam logic [11:0] OFS_STSFLG = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_POP = 12'h01c;
    localparam logic [11:0] OFS_OUTHDR = 12'h020;
    localparam logic [11:0] OFS_OUTDAT = 12'h024;
    localparam logic [11:0] OFS_DEDFLG = 12'h028;
    localparam logic [11:0] OFS_DEDID0 = 12'h030;

    // Field positions
    localparam int CH_LSB = 0;
    localparam int FID_LSB = 2;
    localparam int CYF_LSB = 16;
    localparam int RSS_BIT = 23;
    localparam int RNF_BIT = 24;
    localparam int IDENT_DONT_CARE_MASK_LSB = 2;
    localparam int FFB_LSB = 0;
    localparam int LCB_LSB = 16;
    localparam int ERR_OVR_BIT = 0;
    localparam int ERR_EMPTY_BIT = 1;
    localparam int STS_NE_BIT = 0;
    localparam int STS_CL_BIT = 1;
    localparam int FSR_NE_BIT = 0;
    localparam int FSR_CL_BIT = 1;
    localparam int FSR_OVR_BIT = 2;
    localparam int FSR_FILL_LSB = 8;
    localparam int OUT_CHB_BIT = 16;
    localparam int OUT_CYC_LSB = 24;

    // Writable bits and reset values
    localparam logic [31:0] FILTER_WMASK = 32'h01ff_1fff;
    localparam logic [31:0] MASK_WMASK = 32'h0000_1ffc;
    localparam logic [31:0] FILTER_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [7:0] CRIT_RST = 8'h80;
    localparam logic [7:0] FFB_RST = 8'h00;
    localparam logic [7:0] LCB_RST = 8'h0f;

    typedef struct packed {
        logic [10:0] id;
        logic chan_b;
        logic [5:0] cycle;
        logic [31:0] data;
    } rff_entry_t;
endpackage
`default_nettype wire

// ---- common/rff_store_if.sv ----
// Port bundle between the FIFO control and its message buffer storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rff_store_if;
    logic wr_en;
    logic [rff_pkg::IDX_W-1:0] wr_idx;
    logic [rff_pkg::IDX_W-1:0] rd_idx;
    rff_pkg::rff_entry_t wr_entry;
    rff_pkg::rff_entry_t rd_entry;
    modport ctrl (output wr_en, wr_idx, wr_entry, rd_idx, input rd_entry);
    modport mem (input wr_en, wr_idx, wr_entry, rd_idx, output rd_entry);
endinterface
`default_nettype wire

// ---- hw/rff_store.sv ----
// Message buffer storage of the FIFO, one entry per buffer, in flops.
// Assumes one write per cycle; reads are combinational by index.
`timescale 1ns/1ps
`default_nettype none
module rff_store (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control side
    rff_store_if.mem bus
);
    rff_pkg::rff_entry_t ram_reg [rff_pkg::NUM_BUF];
    rff_pkg::rff_entry_t ram_next [rff_pkg::NUM_BUF];

    always_comb begin
        ram_next = ram_reg;
        if (bus.wr_en) begin
            ram_next[bus.wr_idx] = bus.wr_entry;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < rff_pkg::NUM_BUF; i++) begin
                ram_reg[i] <= '0;
            end
        end else begin
            ram_reg <= ram_next;
        end
    end

    assign bus.rd_entry = ram_reg[bus.rd_idx];
endmodule
`default_nettype wire

// ---- hw/rff_top.sv ----
// Receive frame FIFO with rejection filter, dedicated buffer bypass,
// fill level, critical level, overrun and empty-access flags.
// Assumes frames arrive from protocol logic on core_clk, one per cycle.
`timescale 1ns/1ps
`default_nettype none
module rff_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frames from the protocol engine
    input wire logic frm_valid,
    input wire logic frm_on_a,
    input wire logic frm_on_b,
    input wire logic [10:0] frm_id,
    input wire logic [5:0] frm_cycle,
    input wire logic frm_static,
    input wire logic frm_null,
    input wire logic [31:0] frm_data,
    output logic frm_ready
);
    typedef logic [rff_pkg::IDX_W-1:0] rff_ptr_t;

    logic [31:0] filter_reg, filter_next, mask_reg, mask_next;
    logic [7:0] crit_reg, crit_next, ffb_reg, ffb_next, lcb_reg, lcb_next;
    logic [10:0] ded_id_reg [rff_pkg::NUM_DED];
    logic [10:0] ded_id_next [rff_pkg::NUM_DED];
    logic [rff_pkg::NUM_DED-1:0] ded_flg_reg, ded_flg_next, ded_hit;
    logic err_ovr_reg, err_ovr_next, err_empty_reg, err_empty_next;
    logic sts_ne_reg, sts_ne_next, sts_cl_reg, sts_cl_next;
    logic fsr_ovr_reg, fsr_ovr_next;
    logic [7:0] level_reg, level_next, depth;
    rff_ptr_t wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic pend_reg, pend_next, pend_static_reg, pend_static_next;
    logic pend_null_reg, pend_null_next;
    rff_pkg::rff_entry_t pend_entry_reg, pend_entry_next;
    rff_pkg::rff_entry_t out_entry_reg, out_entry_next, cp_entry;
    logic [31:0] prdata_reg, prdata_next;
    logic cp_valid, cp_static, cp_null, pass, store_evt, overrun_evt;
    logic pop_req, pop_ok, empty_evt, eff_full, wr_acc, addr_ok;
    logic [7:0] lcb_eff;
    rff_store_if st_if ();

    function automatic logic id_rejected(input logic [10:0] frame_ident_filter,
                                         input logic [10:0] dc,
                                         input logic [10:0] id);
        id_rejected = (frame_ident_filter != 11'h000) && (((id ^ frame_ident_filter) & ~dc) == 11'h000);
    endfunction

    // Nonzero field: highest set bit sets repetition, lower bits the base
    function automatic logic cycle_hit(input logic [6:0] cycle_filter,
                                       input logic [5:0] cyc);
        int k;
        logic [6:0] m;
        k = 0;
        for (int i = 0; i < 7; i++) begin
            if (cycle_filter[i]) begin
                k = i;
            end
        end
        m = 7'((7'h01 << k) - 7'h01);
        cycle_hit = (cycle_filter == 7'h00) || ((({1'b0, cyc} ^ cycle_filter) & m) == 7'h00);
    endfunction

    function automatic rff_ptr_t ptr_inc(input rff_ptr_t p,
                                         input logic [7:0] d);
        ptr_inc = (({4'h0, p} + 8'h01) >= d) ? '0 : p + 4'h1;
    endfunction

    function automatic logic crit_on(input logic [7:0] lvl,
                                     input logic [7:0] cl);
        crit_on = (lvl != 8'h00) && (lvl >= cl);
    endfunction

    assign frm_ready = !pend_reg;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign wr_acc = psel && penable && pwrite;
    assign pslverr = psel && penable && !addr_ok;

    // FIFO depth is last-first+1, stored from buffer 0 up; dedicated ids are those below first
    assign lcb_eff = (lcb_reg > rff_pkg::LAST_BUF) ? rff_pkg::LAST_BUF
                                                   : lcb_reg;
    assign depth = (lcb_eff >= ffb_reg) ? 8'(lcb_eff - ffb_reg + 8'h01)
                                        : 8'h00;

    always_comb begin
        // Current copy: a held channel B copy goes before new frames
        cp_valid = pend_reg || (frm_valid && (frm_on_a || frm_on_b));
        cp_entry = pend_reg ? pend_entry_reg
                            : {frm_id, !frm_on_a, frm_cycle, frm_data};
        cp_static = pend_reg ? pend_static_reg : frm_static;
        cp_null = pend_reg ? pend_null_reg : frm_null;
        pend_next = !pend_reg && frm_valid && frm_on_a && frm_on_b;
        pend_entry_next = {frm_id, 1'b1, frm_cycle, frm_data};
        pend_static_next = frm_static;
        pend_null_next = frm_null;
        for (int i = 0; i < rff_pkg::NUM_DED; i++) begin
            ded_hit[i] = cp_valid && (i < int'(ffb_reg)) &&
                         (ded_id_reg[i] != 11'h000) &&
                         (ded_id_reg[i] == cp_entry.id);
        end
        pass = !(cycle_hit(filter_reg[rff_pkg::CYF_LSB +: 7],
                           cp_entry.cycle) &&
                 (filter_reg[rff_pkg::CH_LSB + int'(cp_entry.chan_b)] ||
                  id_rejected(filter_reg[rff_pkg::FID_LSB +: 11],
                              mask_reg[rff_pkg::IDENT_DONT_CARE_MASK_LSB +: 11],
                              cp_entry.id))) &&
               !(filter_reg[rff_pkg::RSS_BIT] && cp_static) &&
               !(filter_reg[rff_pkg::RNF_BIT] && cp_static && cp_null);
        // Null frame handling above
        store_evt = cp_valid && (ded_hit == '0) && pass &&
                    (depth != 8'h00);
        pop_req = wr_acc && (paddr == rff_pkg::OFS_POP) &&
                  (pwdata[7:0] == ffb_reg);
        pop_ok = pop_req && (level_reg != 8'h00);
        empty_evt = pop_req && (level_reg == 8'h00);
        eff_full = (level_reg == depth) && !pop_ok;
        overrun_evt = store_evt && eff_full;
        // Pointers and fill level
        wr_ptr_next = store_evt ? ptr_inc(wr_ptr_reg, depth) : wr_ptr_reg;
        rd_ptr_next = (pop_ok || overrun_evt) ? ptr_inc(rd_ptr_reg, depth)
                                              : rd_ptr_reg;
        level_next = level_reg;
        if (store_evt && !eff_full && !pop_ok) begin
            level_next = level_reg + 8'h01;
        end else if (pop_ok && !store_evt) begin
            level_next = level_reg - 8'h01;
        end // Overrun leaves the level at depth
        out_entry_next = pop_ok ? st_if.rd_entry : out_entry_reg;
        // Flags; a setting event beats a clear in the same cycle, except that a RAMCFG write zeroes NE and CL and a CRIT write above the level zeroes CL
        err_ovr_next = (err_ovr_reg && !pop_ok &&
                        !(wr_acc && paddr == rff_pkg::OFS_ERRFLG &&
                          pwdata[rff_pkg::ERR_OVR_BIT])) ||
                       overrun_evt;
        fsr_ovr_next = (fsr_ovr_reg && !pop_ok) || overrun_evt;
        err_empty_next = (err_empty_reg &&
                          !(wr_acc && paddr == rff_pkg::OFS_ERRFLG &&
                            pwdata[rff_pkg::ERR_EMPTY_BIT])) || empty_evt;
        sts_ne_next = (sts_ne_reg && (level_next != 8'h00) &&
                       !(wr_acc && paddr == rff_pkg::OFS_STSFLG &&
                         pwdata[rff_pkg::STS_NE_BIT])) ||
                      (store_evt && level_reg == 8'h00);
        sts_cl_next = (sts_cl_reg && crit_on(level_next, crit_reg) &&
                       !(wr_acc && paddr == rff_pkg::OFS_STSFLG &&
                         pwdata[rff_pkg::STS_CL_BIT])) ||
                      (crit_on(level_next, crit_reg) &&
                       !crit_on(level_reg, crit_reg));
        ded_flg_next = ded_flg_reg | ded_hit;
        // Configuration writes
        filter_next = filter_reg;
        mask_next = mask_reg;
        crit_next = crit_reg;
        ffb_next = ffb_reg;
        lcb_next = lcb_reg;
        ded_id_next = ded_id_reg;
        if (wr_acc) begin
            if (paddr == rff_pkg::OFS_FILTER) begin
                filter_next = pwdata & rff_pkg::FILTER_WMASK;
            end else if (paddr == rff_pkg::OFS_MASK) begin
                mask_next = pwdata & rff_pkg::MASK_WMASK;
            end else if (paddr == rff_pkg::OFS_CRIT) begin
                crit_next = pwdata[7:0];
                sts_cl_next = sts_cl_next && crit_on(level_next, pwdata[7:0]);
            end else if (paddr == rff_pkg::OFS_RAMCFG) begin
                // Reshaping the ring drops its content
                ffb_next = pwdata[rff_pkg::FFB_LSB +: 8];
                lcb_next = pwdata[rff_pkg::LCB_LSB +: 8];
                wr_ptr_next = '0;
                rd_ptr_next = '0;
                level_next = 8'h00;
                fsr_ovr_next = overrun_evt;
                sts_ne_next = 1'b0;
                sts_cl_next = 1'b0;
            end else if (paddr == rff_pkg::OFS_DEDFLG) begin
                ded_flg_next = (ded_flg_reg &
                                ~pwdata[rff_pkg::NUM_DED-1:0]) | ded_hit;
            end else begin
                for (int i = 0; i < rff_pkg::NUM_DED; i++) begin
                    if (paddr == rff_pkg::OFS_DEDID0 + 12'(4 * i)) begin
                        ded_id_next[i] = pwdata[10:0];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            filter_reg <= rff_pkg::FILTER_RST;
            mask_reg <= rff_pkg::MASK_RST;
            crit_reg <= rff_pkg::CRIT_RST;
            ffb_reg <= rff_pkg::FFB_RST;
            lcb_reg <= rff_pkg::LCB_RST;
            for (int i = 0; i < rff_pkg::NUM_DED; i++) begin
                ded_id_reg[i] <= 11'h000;
            end
            ded_flg_reg <= '0;
            err_ovr_reg <= 1'b0;
            err_empty_reg <= 1'b0;
            sts_ne_reg <= 1'b0;
            sts_cl_reg <= 1'b0;
            fsr_ovr_reg <= 1'b0;
            level_reg <= 8'h00;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            pend_reg <= 1'b0;
            pend_entry_reg <= '0;
            pend_static_reg <= 1'b0;
            pend_null_reg <= 1'b0;
            out_entry_reg <= '0;
        end else begin
            filter_reg <= filter_next;
            mask_reg <= mask_next;
            crit_reg <= crit_next;
            ffb_reg <= ffb_next;
            lcb_reg <= lcb_next;
            ded_id_reg <= ded_id_next;
            ded_flg_reg <= ded_flg_next;
            err_ovr_reg <= err_ovr_next;
            err_empty_reg <= err_empty_next;
            sts_ne_reg <= sts_ne_next;
            sts_cl_reg <= sts_cl_next;
            fsr_ovr_reg <= fsr_ovr_next;
            level_reg <= level_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            pend_reg <= pend_next;
            pend_entry_reg <= pend_entry_next;
            pend_static_reg <= pend_static_next;
            pend_null_reg <= pend_null_next;
            out_entry_reg <= out_entry_next;
        end
    end

    assign st_if.wr_en = store_evt;
    assign st_if.wr_idx = wr_ptr_reg;
    assign st_if.wr_entry = cp_entry;
    assign st_if.rd_idx = rd_ptr_reg;

    rff_store u_store (
        .core_clk(core_clk),
        .resetn(resetn),
        .bus(st_if.mem)
    );

    // Read data is captured in the setup cycle and held for the access
    always_comb begin
        prdata_next = prdata_reg;
        addr_ok = 1'b1;
        if (paddr == rff_pkg::OFS_FILTER) begin
            prdata_next = filter_reg;
        end else if (paddr == rff_pkg::OFS_MASK) begin
            prdata_next = mask_reg;
        end else if (paddr == rff_pkg::OFS_CRIT) begin
            prdata_next = {24'h000000, crit_reg};
        end else if (paddr == rff_pkg::OFS_RAMCFG) begin
            prdata_next = {8'h00, lcb_reg, 8'h00, ffb_reg};
        end else if (paddr == rff_pkg::OFS_ERRFLG) begin
            prdata_next = '0;
            prdata_next[rff_pkg::ERR_OVR_BIT] = err_ovr_reg;
            prdata_next[rff_pkg::ERR_EMPTY_BIT] = err_empty_reg;
        end else if (paddr == rff_pkg::OFS_STSFLG) begin
            prdata_next = '0;
            prdata_next[rff_pkg::STS_NE_BIT] = sts_ne_reg;
            prdata_next[rff_pkg::STS_CL_BIT] = sts_cl_reg;
        end else if (paddr == rff_pkg::OFS_STATUS) begin
            prdata_next = '0;
            prdata_next[rff_pkg::FSR_NE_BIT] = level_reg != 8'h00;
            prdata_next[rff_pkg::FSR_CL_BIT] = crit_on(level_reg, crit_reg);
            prdata_next[rff_pkg::FSR_OVR_BIT] = fsr_ovr_reg;
            prdata_next[rff_pkg::FSR_FILL_LSB +: 8] = level_reg;
        end else if (paddr == rff_pkg::OFS_POP) begin
            prdata_next = '0;
        end else if (paddr == rff_pkg::OFS_OUTHDR) begin
            prdata_next = '0;
            prdata_next[10:0] = out_entry_reg.id;
            prdata_next[rff_pkg::OUT_CHB_BIT] = out_entry_reg.chan_b;
            prdata_next[rff_pkg::OUT_CYC_LSB +: 6] = out_entry_reg.cycle;
        end else if (paddr == rff_pkg::OFS_OUTDAT) begin
            prdata_next = out_entry_reg.data;
        end else if (paddr == rff_pkg::OFS_DEDFLG) begin
            prdata_next = {28'h0000000, ded_flg_reg};
        end else if (paddr[11:4] == rff_pkg::OFS_DEDID0[11:4] &&
                     paddr[1:0] == 2'b00) begin
            prdata_next = {21'h0, ded_id_reg[paddr[3:2]]};
        end else begin
            prdata_next = '0;
            addr_ok = 1'b0;
        end
        if (!(psel && !penable)) begin
            prdata_next = prdata_reg;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_accept_open;
        (filter_reg == 32'h0) && cp_valid && (ded_hit == '0) &&
        (depth != 8'h00) |-> store_evt;
    endproperty
    a_accept_open: assert property (p_accept_open)
        else $error("open filter dropped a frame");
    property p_ded_bypass;
        (ded_hit != '0) |-> !store_evt ##1 (ded_flg_reg != '0);
    endproperty
    a_ded_bypass: assert property (p_ded_bypass)
        else $error("dedicated frame entered fifo");
    property p_level_up;
        store_evt && !eff_full && !pop_ok &&
        !(wr_acc && paddr == rff_pkg::OFS_RAMCFG) |=>
            level_reg == $past(level_reg) + 8'h01;
    endproperty
    a_level_up: assert property (p_level_up)
        else $error("fill level did not count up");
    property p_ne_set;
        store_evt && (level_reg == 8'h00) &&
        !(wr_acc && paddr == rff_pkg::OFS_RAMCFG) |=> sts_ne_reg;
    endproperty
    a_ne_set: assert property (p_ne_set)
        else $error("not-empty flag not set");
    property p_crit_set;
        store_evt && !eff_full && !pop_ok &&
        (level_reg + 8'h01 == crit_reg) && !(wr_acc &&
        (paddr == rff_pkg::OFS_RAMCFG || paddr == rff_pkg::OFS_CRIT)) |=>
            sts_cl_reg;
    endproperty
    a_crit_set: assert property (p_crit_set)
        else $error("critical flag not set");
    property p_overrun;
        overrun_evt && !(wr_acc && paddr == rff_pkg::OFS_RAMCFG) |=>
            err_ovr_reg && fsr_ovr_reg && (level_reg == $past(depth)) &&
            (rd_ptr_reg == wr_ptr_reg);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun handling wrong");
    property p_two_copies;
        frm_valid && frm_ready && frm_on_a && frm_on_b |=>
            pend_reg && cp_entry.chan_b ##1 !pend_reg;
    endproperty
    a_two_copies: assert property (p_two_copies)
        else $error("second channel copy not processed");
    property p_empty_pop;
        empty_evt |=> err_empty_reg && (level_reg == $past(level_next));
    endproperty
    a_empty_pop: assert property (p_empty_pop)
        else $error("empty access flag not set");
    property p_flags_clear;
        !crit_on(level_reg, crit_reg) |-> !sts_cl_reg &&
            ((level_reg != 8'h00) || !sts_ne_reg);
    endproperty
    a_flags_clear: assert property (p_flags_clear)
        else $error("status flag stayed set");

    c_overrun: cover property (overrun_evt);
    c_empty_pop: cover property (empty_evt);
    c_two_copies: cover property (pend_reg && store_evt);
    c_crit_drop: cover property (sts_cl_reg ##1 !sts_cl_reg);
endmodule
`default_nettype wire

// ---- dv/rff_engine_model.sv ----
// Protocol engine model that offers received frames to the FIFO.
// Assumes frm_ready is settled before each rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module rff_engine_model (
    // Clock and handshake
    input wire logic core_clk,
    input wire logic frm_ready,
    // Frame port
    output logic frm_valid,
    output logic frm_on_a,
    output logic frm_on_b,
    output logic [10:0] frm_id,
    output logic [5:0] frm_cycle,
    output logic frm_static,
    output logic frm_null,
    output logic [31:0] frm_data
);
    int timeouts = 0;
    initial begin
        {frm_valid, frm_on_a, frm_on_b, frm_static, frm_null} = 5'h0;
        {frm_id, frm_cycle, frm_data} = '1;
    end
    // Holds the frame until frm_ready is seen high, for at most 20 cycles, then drops frm_valid and scrambles it
    task automatic send(input logic [10:0] id, input logic a, b, s, n,
            input logic [5:0] cyc);
        int k;
        @(posedge core_clk);
        {frm_valid, frm_on_a, frm_on_b} <= {1'h1, a, b};
        {frm_static, frm_null} <= {s, n};
        {frm_id, frm_cycle, frm_data} <= {id, cyc, 21'h0, id};
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (frm_ready === 1'h1) break;
        end
        if (k == 20) timeouts++;
        {frm_valid, frm_id, frm_data} <= {1'h0, ~id, 21'h1f_ffff, ~id};
    endtask
endmodule
`default_nettype wire

// ---- dv/rff_top_tb_top.sv ----
// Testbench of the receive frame FIFO: APB host plus engine model.
// Assumes pready may come late; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module rff_top_tb_top;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic frm_valid, frm_on_a, frm_on_b, frm_static, frm_null, frm_ready;
    logic slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, frm_data;
    logic [10:0] frm_id;
    logic [5:0] frm_cycle;
    logic [43:0] r;
    int error_cnt = 0;
    int samples_checked = 0;
    // id, a, b, static, null, cycle, level, overrun
    logic [43:0] rows [10] = '{44'h002_1_0_1_0_08_0_0,
        44'h003_1_0_1_1_08_0_0, 44'h005_1_0_1_0_08_1_0,
        44'h006_1_0_1_1_08_2_0, 44'h007_1_0_0_0_08_3_0,
        44'h008_0_1_0_0_08_4_0, 44'h009_1_0_0_0_08_5_0,
        44'h005_1_1_1_0_09_5_1, 44'h008_0_1_0_0_09_5_1,
        44'h009_1_0_0_0_09_5_1};
    logic [31:0] pops [5] = '{32'h0800_0009, 32'h0900_0005,
        32'h0900_0005, 32'h0900_0008, 32'h0900_0009};

    rff_top i_rff_top (.core_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .frm_valid,
        .frm_on_a, .frm_on_b, .frm_id, .frm_cycle, .frm_static,
        .frm_null, .frm_data, .frm_ready);
    rff_engine_model i_rff_engine_model (.core_clk, .frm_ready,
        .frm_valid, .frm_on_a, .frm_on_b, .frm_id, .frm_cycle,
        .frm_static, .frm_null, .frm_data);

    function automatic logic [31:0] st(input logic [3:0] l, input logic o);
        return {20'h0, l, 5'h0, o, l >= 4'h3, l != 4'h0};
    endfunction

    task automatic summarize();
        error_cnt += i_rff_engine_model.timeouts;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge core_clk);
        penable <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'h1) break;
        end
        q = prdata;
        slverr = pslverr;
        {psel, penable} <= 2'h0;
        if (k == 20) begin
            error_cnt++;
            summarize();
        end
    endtask

    // Offers one frame; a frame the engine could not hand over ends the run
    task automatic frame(input logic [10:0] id, input logic a, b, s, n,
            input logic [5:0] cyc);
        i_rff_engine_model.send(id, a, b, s, n, cyc);
        if (i_rff_engine_model.timeouts != 0) summarize();
    endtask

    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'h1;
        apb(1'h0, 12'h008, 32'h0, rd);
        chk("crit reset", 32'h80, rd);
        apb(1'h0, 12'h018, 32'h0, rd);
        chk("status reset", 32'h0, rd);
        apb(1'h1, 12'h030, 32'h2, rd);
        apb(1'h1, 12'h034, 32'h3, rd);
        apb(1'h1, 12'h00c, 32'h0007_0003, rd);
        apb(1'h1, 12'h008, 32'h3, rd);
        apb(1'h1, 12'h000, 32'h0, rd);
        apb(1'h1, 12'h004, 32'h0, rd);
        foreach (rows[i]) begin
            r = rows[i];
            frame(r[42:32], r[28], r[24], r[20], r[16], r[13:8]);
            apb(1'h0, 12'h018, 32'h0, rd);
            chk("status", st(r[7:4], r[0]), rd);
        end
        $display("frame table done");
        apb(1'h0, 12'h028, 32'h0, rd);
        chk("dedicated hits", 32'h3, rd);
        apb(1'h0, 12'h010, 32'h0, rd);
        chk("overrun", 32'h1, rd);
        apb(1'h0, 12'h014, 32'h0, rd);
        chk("status flags", 32'h3, rd);
        apb(1'h1, 12'h01c, 32'h4, rd);
        apb(1'h0, 12'h018, 32'h0, rd);
        chk("wrong index pop", st(4'h5, 1'h1), rd);
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 12'h01c, 32'h3, rd);
            apb(1'h0, 12'h020, 32'h0, rd);
            chk("header", pops[i], rd & 32'h3f00_07ff);
            apb(1'h0, 12'h024, 32'h0, rd);
            chk("data", {21'h0, pops[i][10:0]}, rd);
            apb(1'h0, 12'h018, 32'h0, rd);
            chk("level", st(4'(4 - i), 1'h0), rd);
        end
        apb(1'h0, 12'h014, 32'h0, rd);
        chk("status flags cleared", 32'h0, rd);
        $display("read out done");
        apb(1'h1, 12'h01c, 32'h3, rd);
        apb(1'h0, 12'h010, 32'h0, rd);
        chk("empty pop", 32'h2, rd);
        apb(1'h0, 12'h02c, 32'h0, rd);
        chk("unmapped", 32'h1, {rd[30:0], slverr});
        // Static reject, ID 0x010 with bit 0 don't care, channel B reject
        apb(1'h1, 12'h000, 32'h0080_0042, rd);
        apb(1'h1, 12'h004, 32'h0000_0004, rd);
        frame(11'h011, 1'h1, 1'h0, 1'h0, 1'h0, 6'h09);
        frame(11'h020, 1'h0, 1'h1, 1'h0, 1'h0, 6'h09);
        frame(11'h021, 1'h1, 1'h0, 1'h1, 1'h0, 6'h09);
        apb(1'h0, 12'h018, 32'h0, rd);
        chk("rejected frames", st(4'h0, 1'h0), rd);
        frame(11'h012, 1'h1, 1'h0, 1'h0, 1'h0, 6'h09);
        apb(1'h0, 12'h018, 32'h0, rd);
        chk("filtered pass", st(4'h1, 1'h0), rd);
        $display("awkward cases done");
        @(posedge core_clk);
        resetn <= 1'h0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'h1;
        apb(1'h0, 12'h018, 32'h0, rd);
        chk("status after reset", 32'h0, rd);
        apb(1'h0, 12'h000, 32'h0, rd);
        chk("filter after reset", 32'h0, rd);
        $display("reset case done");
        summarize();
    end
endmodule
`default_nettype wire
